/* File: rtl/phy_basic_mode_control_pkg.sv */
/*
 * Package for the basic mode control and status register pair.
 * Holds register indices, field positions, reset values and timing counts.
 * Assumes a 250 MHz core clock; the control/status module and the testbench import it whole.
 */
`default_nettype none
package phy_basic_mode_control_pkg;

	// Register indices on the management register port.
	localparam logic [4:0] REG_CONTROL_IDX = 5'h00;
	localparam logic [4:0] REG_STATUS_IDX  = 5'h01;

	// Control field positions.
	localparam int CTL_RESET_BIT    = 15;
	localparam int CTL_LOOPBACK_BIT = 14;
	localparam int CTL_SPEED_LSB    = 13;
	localparam int CTL_AN_EN_BIT    = 12;
	localparam int CTL_PWRDN_BIT    = 11;
	localparam int CTL_ISOLATE_BIT  = 10;
	localparam int CTL_RESTART_BIT  = 9;
	localparam int CTL_DUPLEX_BIT   = 8;
	localparam int CTL_COLTEST_BIT  = 7;
	localparam int CTL_SPEED_MSB    = 6;

	// Status field positions that change at run time.
	localparam int STS_AN_DONE_BIT = 5;
	localparam int STS_RFAULT_BIT  = 4;
	localparam int STS_LINK_BIT    = 2;

	// Fixed status bits: TX full/half, 10 full/half, extended status,
	// preamble suppression, negotiation ability.
	localparam logic [15:0] STS_FIXED_ONES = 16'h7948;

	// Writable control bits; the reserved low six read as zero.
	localparam logic [15:0] CTL_WRITE_MASK = 16'hFDC0;
	// Control value after reset, ignoring the strapped bits 12 and 8.
	localparam logic [15:0] CTL_RESET_VALUE = 16'h0040;

	// Speed codes formed by {bit 6, bit 13}.
	localparam logic [1:0] SPEED_10   = 2'b00;
	localparam logic [1:0] SPEED_100  = 2'b01;
	localparam logic [1:0] SPEED_1000 = 2'b10;

	// Clock and collision test timing.
	localparam int CLOCK_PERIOD_PS   = 4000;
	localparam int COL_ASSERT_PS     = 512 * 100;
	localparam int COL_DEASSERT_BITS = 4;
	localparam int BIT_TIME_1000_PS  = 1000;
	// Longest time to deassert, at the fastest rate, rounded down, at least one.
	localparam int COL_DEASSERT_CYC_RAW = (COL_DEASSERT_BITS * BIT_TIME_1000_PS) / CLOCK_PERIOD_PS;
	localparam int COL_DEASSERT_CYC = (COL_DEASSERT_CYC_RAW < 1) ? 1 : COL_DEASSERT_CYC_RAW;

	// Speed chosen by the forced field, as a two-bit mode.
	function automatic logic [1:0] speed_decode(input logic [15:0] ctl);
		speed_decode = {ctl[CTL_SPEED_MSB], ctl[CTL_SPEED_LSB]};
	endfunction

endpackage
`default_nettype wire

/* File: rtl/latch_event_bit.sv */
/*
 * One latched status bit, latching high or low on its event.
 * Assumes a single clock and a read strobe one cycle long.
 */
`timescale 1ns/10ps
`default_nettype none
module latch_event_bit #(
	parameter bit LATCH_HIGH = 1'b1
) (
	input  wire logic clock,
	input  wire logic srst,
	input  wire logic event_in,
	input  wire logic cond_in,
	input  wire logic read_pulse,
	output logic      value
);
	logic value_reg;
	logic value_next;

	// Event wins over the read release; a read restores the live condition.
	always_comb begin
		value_next = value_reg;
		if (read_pulse) begin
			value_next = cond_in;
		end
		if (event_in) begin
			value_next = LATCH_HIGH;
		end
	end

	// Registers the bit; latched-low bits start at zero too.
	always_ff @(posedge clock) begin
		if (srst) begin
			value_reg <= 1'b0;
		end else begin
			value_reg <= value_next;
		end
	end

	assign value = value_reg;
endmodule // latch_event_bit
`default_nettype wire

/* File: rtl/phy_basic_control_status.sv */
/*
 * Basic mode control and status register pair of an Ethernet PHY.
 * Assumes a management engine that presents one-cycle read and write strobes
 * with a 5-bit register index, and PHY core signals synchronous to clock.
 */
`timescale 1ns/10ps
`default_nettype none
//
// Overview of operation
// - Isolate bit 10 cuts the MAC data interface; management stays usable.
// - Writing restart bit 9 restarts negotiation, ignored when bit 12 is zero.
// - Restart bit reads one until negotiation actually starts, then self-clears.
// - Writing zero to restart bit does not disturb a running negotiation.
// - With negotiation off, bit 8 picks full (1) or half (0) duplex.
// - Collision test bit 7 raises COL within 512 bit times of TX_EN.
// - In collision test COL drops within 4 bit times of TX_EN falling.
// - Bit 6 is forced speed MSB with bit 13, resetting to one.
// - Speed 10 is gigabit, 01 is 100, 00 is 10, 11 reserved.
// - Negotiation enable makes bits 8 and 13 ignored; otherwise they rule.
// - Control bits 5 to 0 ignore writes and read zero.
// - Status bits 15, 10 and 9 read zero always.
// - Status bits 14 and 13 read one always.
// - Status bits 12 and 11 read one always.
// - Status bit 8 reads one, extended status exists.
// - Status bit 7 is reserved and reads zero.
// - Preamble-free transfers accepted, status bit 6 is one; controller preambles once.
// - Status bit 5 shows negotiation complete.
// - Status bit 4 latches high on remote fault until read or reset.
// - Status bit 3 reads one, negotiation ability.
// - Status bit 2 clears on link failure; set again only after good link and read.
// - Latched-high bits set by event, latched-low cleared by event, held until read.
module phy_basic_control_status
	import phy_basic_mode_control_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        strap_an_enable,
	input  wire logic        strap_full_duplex,
	input  wire logic        mgmt_write,
	input  wire logic        mgmt_read,
	input  wire logic [4:0]  mgmt_index,
	input  wire logic [15:0] mgmt_wdata,
	output logic      [15:0] mgmt_rdata,
	output logic             mgmt_rvalid,
	input  wire logic        an_started,
	input  wire logic        an_complete,
	input  wire logic        remote_fault_event,
	input  wire logic        link_good,
	input  wire logic        tx_en,
	input  wire logic        col_in,
	output logic             col,
	output logic             isolate,
	output logic             an_enable,
	output logic             an_restart,
	output logic             full_duplex,
	output logic      [1:0]  speed_mode,
	output logic             loopback,
	output logic             power_down,
	output logic             soft_reset
);

	// Control register state.
	logic [15:0] ctl_reg;
	logic [15:0] ctl_next;
	logic        strap_pending_reg;
	logic        strap_pending_next;

	// Output flops.
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic        rvalid_reg;
	logic        rvalid_next;
	logic        col_reg;
	logic        col_next;
	logic        restart_pulse_reg;
	logic        restart_pulse_next;
	logic        full_duplex_reg;
	logic        full_duplex_next;
	logic [1:0]  speed_reg;
	logic [1:0]  speed_next;

	logic        wr_ctl;
	logic        rd_sts;
	logic        link_fail;
	logic        rfault_bit;
	logic        link_bit;
	logic [15:0] status_word;

	assign wr_ctl = mgmt_write && (mgmt_index == REG_CONTROL_IDX);
	assign rd_sts = mgmt_read && (mgmt_index == REG_STATUS_IDX);
	assign link_fail = !link_good;

	// Remote fault latches high and holds until a status read.
	latch_event_bit #(
		.LATCH_HIGH (1'b1)
	) rfault_latch (
		.clock      (clock),
		.srst       (srst),
		.event_in   (remote_fault_event),
		.cond_in    (remote_fault_event),
		.read_pulse (rd_sts),
		.value      (rfault_bit)
	);

	// Link status latches low on failure, rises only on a read with good link.
	latch_event_bit #(
		.LATCH_HIGH (1'b0)
	) link_latch (
		.clock      (clock),
		.srst       (srst),
		.event_in   (link_fail),
		.cond_in    (link_good),
		.read_pulse (rd_sts),
		.value      (link_bit)
	);

	// Status word from fixed abilities and live state.
	always_comb begin
		status_word = STS_FIXED_ONES;
		status_word[STS_AN_DONE_BIT] = an_complete;
		status_word[STS_RFAULT_BIT]  = rfault_bit;
		status_word[STS_LINK_BIT]    = link_bit;
	end

	// Control register next value, restart handshake and strap capture.
	always_comb begin
		ctl_next = ctl_reg;
		strap_pending_next = 1'b0;
		restart_pulse_next = 1'b0;
		if (strap_pending_reg) begin
			ctl_next[CTL_AN_EN_BIT]  = strap_an_enable;
			ctl_next[CTL_DUPLEX_BIT] = strap_full_duplex;
		end
		if (wr_ctl) begin
			// Reserved low bits never store; restart bit only sets, unless bit 12 is written zero, which clears it.
			ctl_next = (mgmt_wdata & CTL_WRITE_MASK & ~(16'h0001 << CTL_RESTART_BIT))
				| (ctl_reg & (16'h0001 << CTL_RESTART_BIT));
			if (mgmt_wdata[CTL_RESTART_BIT] && mgmt_wdata[CTL_AN_EN_BIT]) begin
				ctl_next[CTL_RESTART_BIT] = 1'b1;
				restart_pulse_next = 1'b1;
			end
			if (!mgmt_wdata[CTL_AN_EN_BIT]) begin
				ctl_next[CTL_RESTART_BIT] = 1'b0;
			end
		end
		// Self-clear once negotiation has really begun.
		if (ctl_reg[CTL_RESTART_BIT] && an_started && !restart_pulse_next) begin
			ctl_next[CTL_RESTART_BIT] = 1'b0;
		end
		// Software reset restores defaults and re-takes straps.
		if (ctl_reg[CTL_RESET_BIT]) begin
			ctl_next = CTL_RESET_VALUE;
			strap_pending_next = 1'b1;
		end
	end

	// Registers control state; straps are caught on the cycle after reset.
	always_ff @(posedge clock) begin
		if (srst) begin
			ctl_reg           <= CTL_RESET_VALUE;
			strap_pending_reg <= 1'b1;
			restart_pulse_reg <= 1'b0;
		end else begin
			ctl_reg           <= ctl_next;
			strap_pending_reg <= strap_pending_next;
			restart_pulse_reg <= restart_pulse_next;
		end
	end

	// Read data held stable; a read returns values before any release.
	always_comb begin
		rdata_next  = rdata_reg;
		rvalid_next = mgmt_read;
		if (mgmt_read) begin
			case (mgmt_index)
				REG_CONTROL_IDX: rdata_next = ctl_reg & (CTL_WRITE_MASK | (16'h0001 << CTL_RESTART_BIT));
				REG_STATUS_IDX:  rdata_next = status_word;
				default:         rdata_next = 16'h0000;
			endcase
		end
	end

	// Forced speed and duplex apply only with negotiation off.
	always_comb begin
		full_duplex_next = full_duplex_reg;
		speed_next = speed_reg;
		if (!ctl_reg[CTL_AN_EN_BIT]) begin
			full_duplex_next = ctl_reg[CTL_DUPLEX_BIT];
			if (speed_decode(ctl_reg) != 2'b11) begin
				speed_next = speed_decode(ctl_reg);
			end
		end
	end

	// Collision test loops TX_EN to COL one cycle later, well inside 512 bit times and just at the 4 bit time limit at gigabit.
	always_comb begin
		if (ctl_reg[CTL_ISOLATE_BIT]) begin
			col_next = 1'b0;
		end else if (ctl_reg[CTL_COLTEST_BIT]) begin
			col_next = tx_en;
		end else begin
			col_next = col_in;
		end
	end

	// Registers outputs.
	always_ff @(posedge clock) begin
		if (srst) begin
			rdata_reg       <= 16'h0000;
			rvalid_reg      <= 1'b0;
			col_reg         <= 1'b0;
			full_duplex_reg <= 1'b0;
			speed_reg       <= SPEED_1000;
		end else begin
			rdata_reg       <= rdata_next;
			rvalid_reg      <= rvalid_next;
			col_reg         <= col_next;
			full_duplex_reg <= full_duplex_next;
			speed_reg       <= speed_next;
		end
	end

	assign mgmt_rdata  = rdata_reg;
	assign mgmt_rvalid = rvalid_reg;
	assign col         = col_reg;
	assign isolate     = ctl_reg[CTL_ISOLATE_BIT];
	assign an_enable   = ctl_reg[CTL_AN_EN_BIT];
	assign an_restart  = restart_pulse_reg;
	assign full_duplex = full_duplex_reg;
	assign speed_mode  = speed_reg;
	assign loopback    = ctl_reg[CTL_LOOPBACK_BIT];
	assign power_down  = ctl_reg[CTL_PWRDN_BIT];
	assign soft_reset  = ctl_reg[CTL_RESET_BIT];

	// Restart write with negotiation on raises the restart pulse next cycle.
	restart_pulse_a: assert property (@(posedge clock) disable iff (srst)
		(wr_ctl && mgmt_wdata[CTL_RESTART_BIT] && mgmt_wdata[CTL_AN_EN_BIT] && !ctl_reg[CTL_RESET_BIT])
		|=> an_restart && ctl_reg[CTL_RESTART_BIT])
		else $error("Restart write did not start negotiation.");

	// Restart write with negotiation off is ignored.
	restart_ignore_a: assert property (@(posedge clock) disable iff (srst)
		(wr_ctl && !mgmt_wdata[CTL_AN_EN_BIT]) |=> !an_restart && !ctl_reg[CTL_RESTART_BIT])
		else $error("Restart taken while negotiation disabled.");

	// Restart bit clears after negotiation starts.
	restart_clear_a: assert property (@(posedge clock) disable iff (srst)
		(ctl_reg[CTL_RESTART_BIT] && an_started && !wr_ctl && !ctl_reg[CTL_RESET_BIT])
		|=> !ctl_reg[CTL_RESTART_BIT])
		else $error("Restart bit did not self-clear.");

	// Collision test follows TX_EN within one cycle.
	col_follow_a: assert property (@(posedge clock) disable iff (srst)
		(ctl_reg[CTL_COLTEST_BIT] && !ctl_reg[CTL_ISOLATE_BIT] && tx_en) |=> col)
		else $error("COL not raised in collision test.");

	// Collision drops within one cycle after TX_EN falls.
	col_drop_a: assert property (@(posedge clock) disable iff (srst)
		(ctl_reg[CTL_COLTEST_BIT] && $fell(tx_en)) |=> !col)
		else $error("COL held after TX_EN fell.");

	// Reserved control bits read back as zero.
	ctl_reserved_a: assert property (@(posedge clock) disable iff (srst)
		(mgmt_read && mgmt_index == REG_CONTROL_IDX) |=> mgmt_rdata[5:0] == 6'h00)
		else $error("Reserved control bits read nonzero.");

	// Fixed status bits read correctly.
	sts_fixed_a: assert property (@(posedge clock) disable iff (srst)
		rd_sts |=> (mgmt_rdata & 16'hFFC8) == STS_FIXED_ONES)
		else $error("Fixed status bits wrong.");

	// Link bit stays low after failure until a read with good link.
	link_hold_a: assert property (@(posedge clock) disable iff (srst)
		(!link_bit && !rd_sts) |=> !link_bit)
		else $error("Link status rose without a read.");

	// Remote fault holds until read.
	rfault_hold_a: assert property (@(posedge clock) disable iff (srst)
		(rfault_bit && !rd_sts) |=> rfault_bit)
		else $error("Remote fault released without read.");

	// Forced speed and duplex hold while negotiation is enabled.
	forced_hold_a: assert property (@(posedge clock) disable iff (srst)
		ctl_reg[CTL_AN_EN_BIT] |=> $stable(speed_mode) && $stable(full_duplex))
		else $error("Forced speed or duplex changed during negotiation.");

	// Duplex follows bit 8 one cycle later while negotiation is off.
	duplex_follow_a: assert property (@(posedge clock) disable iff (srst)
		!ctl_reg[CTL_AN_EN_BIT] |=> full_duplex == $past(ctl_reg[CTL_DUPLEX_BIT]))
		else $error("Forced duplex not applied.");

	// A valid forced speed code is applied one cycle later.
	speed_follow_a: assert property (@(posedge clock) disable iff (srst)
		(!ctl_reg[CTL_AN_EN_BIT] && speed_decode(ctl_reg) != 2'b11) |=> speed_mode == speed_decode($past(ctl_reg)))
		else $error("Forced speed not applied.");

	// The reserved speed code leaves the speed as it was.
	speed_reserved_a: assert property (@(posedge clock) disable iff (srst)
		(!ctl_reg[CTL_AN_EN_BIT] && speed_decode(ctl_reg) == 2'b11) |=> $stable(speed_mode))
		else $error("Reserved speed code changed the speed.");

	// An isolated port never shows a collision to the MAC.
	isolate_col_a: assert property (@(posedge clock) disable iff (srst)
		ctl_reg[CTL_ISOLATE_BIT] |=> !col)
		else $error("COL driven while isolated.");

	// Read data stays put between reads.
	rdata_hold_a: assert property (@(posedge clock) disable iff (srst)
		!mgmt_read |=> $stable(mgmt_rdata))
		else $error("Read data changed without a read.");

endmodule // phy_basic_control_status
`default_nettype wire

/* File: sim/mgmt_station_model.sv */
/*
 * Station management controller model driving the register strobe port.
 * Assumes a rising-edge clock and that callers serialise transfers.
 */
`timescale 1ns/10ps
`default_nettype none
module mgmt_station_model (
	input  wire logic        clock,
	output logic             mgmt_write,
	output logic             mgmt_read,
	output logic      [4:0]  mgmt_index,
	output logic      [15:0] mgmt_wdata
);
	// Idle values at time zero.
	initial begin
		mgmt_write = 1'b0;
		mgmt_read = 1'b0;
		mgmt_index = 5'h00;
		mgmt_wdata = 16'h0000;
	end

	// Serial framing, including the one preamble after reset, lies outside this port.
	task automatic xfer(input logic wr_n_rd, input logic [4:0] idx, input logic [15:0] data);
		@(posedge clock);
		#1;
		mgmt_index = idx;
		mgmt_wdata = data;
		mgmt_write = wr_n_rd;
		mgmt_read = ~wr_n_rd;
		@(posedge clock);
		#1;
		mgmt_write = 1'b0;
		mgmt_read = 1'b0;
		mgmt_index = ~idx;
		mgmt_wdata = ~data;
	endtask
endmodule // mgmt_station_model
`default_nettype wire

/* File: sim/tb.sv */
/*
 * Self-checking testbench for the basic control and status register pair.
 * Assumes the package constants and the strobe port timing of the design.
 */
`timescale 1ns/10ps
`default_nettype none
module tb
	import phy_basic_mode_control_pkg::*;
;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic        strap_an = 1'b1;
	logic        strap_fd = 1'b0;
	logic        an_started = 1'b0;
	logic        an_complete = 1'b0;
	logic        rf_event = 1'b0;
	logic        link_good = 1'b0;
	logic        tx_en = 1'b0;
	logic        mgmt_write, mgmt_read, mgmt_rvalid, col, isolate, an_restart, full_duplex;
	logic        an_enable, loopback, power_down, soft_reset;
	logic [4:0]  mgmt_index;
	logic [15:0] mgmt_wdata, mgmt_rdata, w;
	logic [1:0]  speed_mode, spd;
	logic [15:0] exp_q[$];
	int          n_errors = 0;
	int          n_compared = 0;
	int          n_restart = 0;
	int          n0;

	always #2 clock = ~clock;

	mgmt_station_model u_mgmt_station_model (.clock(clock), .mgmt_write(mgmt_write),
		.mgmt_read(mgmt_read), .mgmt_index(mgmt_index), .mgmt_wdata(mgmt_wdata));

	phy_basic_control_status u_phy_basic_control_status (.clock(clock), .srst(srst),
		.strap_an_enable(strap_an), .strap_full_duplex(strap_fd), .mgmt_write(mgmt_write),
		.mgmt_read(mgmt_read), .mgmt_index(mgmt_index), .mgmt_wdata(mgmt_wdata),
		.mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .an_started(an_started),
		.an_complete(an_complete), .remote_fault_event(rf_event), .link_good(link_good),
		.tx_en(tx_en), .col_in(1'b0), .col(col), .isolate(isolate), .an_enable(an_enable),
		.an_restart(an_restart), .full_duplex(full_duplex), .speed_mode(speed_mode),
		.loopback(loopback), .power_down(power_down), .soft_reset(soft_reset));

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic report_and_stop();
		if (n_errors == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// A read notes its expected data before the strobe goes out.
	task automatic rd(input logic [4:0] idx, input logic [15:0] exp);
		exp_q.push_back(exp);
		u_mgmt_station_model.xfer(1'b0, idx, 16'h0000);
	endtask

	task automatic wr(input logic [15:0] data);
		u_mgmt_station_model.xfer(1'b1, REG_CONTROL_IDX, data);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	function automatic logic [15:0] sts(input logic an, input logic rf, input logic lk);
		return STS_FIXED_ONES | {10'h000, an, rf, 1'b0, lk, 2'b00};
	endfunction

	// Each read answer is compared with the oldest note.
	always @(posedge clock) begin
		if (mgmt_rvalid === 1'b1) begin
			chk("read data", (exp_q.size() > 0) ? exp_q.pop_front() : ~mgmt_rdata, mgmt_rdata);
		end
		if (an_restart === 1'b1) begin
			n_restart <= n_restart + 1;
		end
	end

	// Main sequence.
	initial begin
		void'($urandom(32'hd889_939d));
		strap_fd = 1'($urandom);
		cyc(10);
		srst = 1'b0;
		cyc(2);
		rd(REG_CONTROL_IDX, CTL_RESET_VALUE | 16'h1000 | (16'(strap_fd) << 8));
		chk("an enable", 16'h0001, 16'(an_enable));
		rd(REG_STATUS_IDX, sts(1'b0, 1'b0, 1'b0));
		rd(5'h07, 16'h0000);
		spd = SPEED_1000;
		// Every forced speed and duplex, with random isolate, test and reserved bits.
		for (int i = 0; i < 8; i++) begin
			w = (16'($urandom) & 16'h4CBF) | (16'(i & 1) << 13) | (16'((i >> 1) & 1) << 6) | (16'(i >> 2) << 8);
			wr(w);
			rd(REG_CONTROL_IDX, w & CTL_WRITE_MASK);
			chk("isolate", 16'(w[10]), 16'(isolate));
			chk("duplex", 16'(w[8]), 16'(full_duplex));
			chk("loopback", 16'(w[14]), 16'(loopback));
			chk("power down", 16'(w[11]), 16'(power_down));
			chk("an enable", 16'h0000, 16'(an_enable));
			if ({w[6], w[13]} != 2'b11) begin
				spd = {w[6], w[13]};
			end
			chk("speed", 16'(spd), 16'(speed_mode));
		end
		wr(16'h3000);
		cyc(2);
		chk("speed", 16'(spd), 16'(speed_mode));
		chk("duplex", 16'h0001, 16'(full_duplex));
		// Restart while negotiating, a zero write, then the start of negotiation.
		n0 = n_restart;
		wr(16'h1200);
		rd(REG_CONTROL_IDX, 16'h1200);
		wr(16'h1000);
		rd(REG_CONTROL_IDX, 16'h1200);
		chk("restart count", 16'(n0 + 1), 16'(n_restart));
		an_started = 1'b1;
		cyc(1);
		an_started = 1'b0;
		rd(REG_CONTROL_IDX, 16'h1000);
		wr(16'h0200);
		rd(REG_CONTROL_IDX, 16'h0000);
		chk("restart count", 16'(n0 + 1), 16'(n_restart));
		// Collision test, then the same with the port isolated.
		wr(16'h0080);
		tx_en = 1'b1;
		cyc(2);
		chk("col", 16'h0001, 16'(col));
		tx_en = 1'b0;
		cyc(1 + COL_DEASSERT_CYC);
		chk("col", 16'h0000, 16'(col));
		wr(16'h0480);
		tx_en = 1'b1;
		cyc(3);
		chk("col", 16'h0000, 16'(col));
		tx_en = 1'b0;
		// Latched link and fault bits, read before and after release.
		link_good = 1'b1;
		rd(REG_STATUS_IDX, sts(1'b0, 1'b0, 1'b0));
		rd(REG_STATUS_IDX, sts(1'b0, 1'b0, 1'b1));
		link_good = 1'b0;
		cyc(1);
		link_good = 1'b1;
		rd(REG_STATUS_IDX, sts(1'b0, 1'b0, 1'b0));
		rf_event = 1'b1;
		cyc(1);
		rf_event = 1'b0;
		rd(REG_STATUS_IDX, sts(1'b0, 1'b1, 1'b1));
		an_complete = 1'b1;
		rd(REG_STATUS_IDX, sts(1'b1, 1'b0, 1'b1));
		// Software reset reloads the defaults and takes the straps again.
		wr(16'h8000);
		chk("soft reset", 16'h0001, 16'(soft_reset));
		cyc(1);
		rd(REG_CONTROL_IDX, CTL_RESET_VALUE | 16'h1000 | (16'(strap_fd) << 8));
		for (int k = 0; k < 20 && exp_q.size() > 0; k++) begin
			cyc(1);
		end
		if (exp_q.size() > 0) begin
			n_errors++;
			$display("wrong value pending reads expected 0 seen %0d", exp_q.size());
		end
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
